// ===== rtl/sfd_pkg.sv
// Constants of the serial flash command decoder: opcodes, phase
// lengths, read spaces and state encodings.
// Assumes the includer imports the whole package.
package sfd_pkg;

   ////////////////////////////////////////////////////////////////////
   // Opcodes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_TWO_OUT = 8'h3B;
   localparam logic [7:0] OP_FOUR_OUT = 8'h6B;
   localparam logic [7:0] OP_TWO_ADDR_DATA = 8'hBB;
   localparam logic [7:0] OP_FOUR_ADDR_DATA = 8'hEB;
   localparam logic [7:0] OP_IDENT = 8'h9F;
   localparam logic [7:0] OP_MAKER_ID = 8'h90;
   localparam logic [7:0] OP_SET_WRITE_EN = 8'h06;
   localparam logic [7:0] OP_CLR_WRITE_EN = 8'h04;
   localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
   localparam logic [7:0] OP_DOUBLE_ERASE = 8'h40;
   localparam logic [7:0] OP_LARGE_ERASE = 8'hD8;
   localparam logic [7:0] OP_ARRAY_ERASE_A = 8'h60;
   localparam logic [7:0] OP_ARRAY_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_FOUR_PAGE_PROG = 8'h32;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_CONFIG_READ = 8'h35;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_CLEAR_FAIL = 8'h30;
   localparam logic [7:0] OP_SLEEP = 8'hB9;
   localparam logic [7:0] OP_WAKE = 8'hAB;
   localparam logic [7:0] OP_OTP_PROG = 8'h42;
   localparam logic [7:0] OP_OTP_READ = 8'h4B;

   ////////////////////////////////////////////////////////////////////
   // Phase lengths in bytes; mode cycles count as header bytes; then data count width, FIFO depth and array address width
   localparam logic [1:0] ADDR_BYTES = 2'h3;
   localparam logic [1:0] ONE_BYTE = 2'h1;
   localparam logic [1:0] THREE_BYTES = 2'h3;
   localparam logic [1:0] NO_BYTES = 2'h0;
   localparam int DATA_CNT_W = 9;
   localparam int FIFO_DEPTH = 8;
   localparam int ARRAY_ADDR_W = 22;

   ////////////////////////////////////////////////////////////////////
   // Read spaces shown to the storage side
   localparam logic [2:0] SPACE_ARRAY = 3'h0;
   localparam logic [2:0] SPACE_OTP = 3'h1;
   localparam logic [2:0] SPACE_IDENT = 3'h2;
   localparam logic [2:0] SPACE_MAKER = 3'h3;
   localparam logic [2:0] SPACE_SIGNATURE = 3'h4;
   localparam logic [2:0] SPACE_STATUS = 3'h5;
   localparam logic [2:0] SPACE_CONFIG = 3'h6;

   typedef enum {K_BAD, K_OUT, K_SILENT, K_IN, K_NODATA} sfd_kind_type;
   typedef enum {S_OPCODE, S_ADDR, S_DUMMY, S_OUT, S_IN, S_END, S_IGNORE} sfd_state_type;

endpackage : sfd_pkg

// ===== rtl/sfd_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are single-bit levels from outside clk_sys_i.
module sfd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule : sfd_sync

// ===== rtl/sfd_fifo.sv
// Shift-style FIFO: the head is always entry 0, so the pop side
// comes straight from flip-flops.
// Assumes push and pop on the same clock; flush wins over both.
module sfd_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic flush_i,
   // Fill side
   input wire logic push_valid_i,
   input wire logic [W-1:0] push_data_i,
   output logic push_ready_o,
   // Drain side
   output logic pop_valid_o,
   output logic [W-1:0] pop_data_o,
   input wire logic pop_ready_i
);

   logic [W-1:0] mem [0:D];
   logic [D:0] vld;
   logic push;
   logic pop;

   assign push = push_valid_i & ~vld[D-1];
   assign pop = pop_ready_i & vld[0];
   assign push_ready_o = ~vld[D-1];
   assign pop_valid_o = vld[0];
   assign pop_data_o = mem[0];
   assign vld[D] = 1'b0;
   assign mem[D] = '0;

   for (genvar i = 0; i < D; i++) begin : g_ent
      logic below;
      if (i == 0) begin : g_first
         assign below = 1'b1;
      end else begin : g_rest
         assign below = vld[i-1];
      end
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
         if (!nrst_i) begin
            vld[i] <= 1'b0;
            mem[i] <= '0;
         end else if (flush_i) begin
            vld[i] <= 1'b0;
         end else if (pop && push) begin
            mem[i] <= vld[i+1] ? mem[i+1] : push_data_i;
         end else if (pop) begin
            mem[i] <= mem[i+1];
            vld[i] <= vld[i+1];
         end else if (push && !vld[i] && below) begin
            mem[i] <= push_data_i;
            vld[i] <= 1'b1;
         end
      end
   end

endmodule : sfd_fifo

// ===== rtl/sfd_decoder.sv
// Serial flash command decoder: opcode, address, dummy and data
// phases on the serial pins, oversampled by clk_sys_i.
// Assumes the serial clock is far slower than clk_sys_i (a few system
// cycles per half period) and that the storage side answers a read
// request before the next serial falling edge.
module sfd_decoder
   import sfd_pkg::*;
#(
   parameter int ADDR_W = ARRAY_ADDR_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Serial pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   // Storage read port
   output logic rd_req_o,
   output logic [23:0] rd_addr_o,
   output logic [2:0] rd_space_o,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i,
   // Write engine
   input wire logic busy_i,
   output logic exec_valid_o,
   output logic [7:0] exec_cmd_o,
   output logic [23:0] exec_addr_o,
   output logic [DATA_CNT_W-1:0] exec_len_o,
   output logic deep_sleep_o,
   output logic overflow_o,
   // Write data stream
   output logic wr_valid_o,
   output logic [7:0] wr_data_o,
   input wire logic wr_ready_i
);

   localparam logic [23:0] ADDR_MASK = 24'((25'h1 << ADDR_W) - 25'h1);

   ////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic sfd_kind_type kind_of(input logic [7:0] op);
      case (op)
         OP_READ, OP_FAST_READ, OP_IDENT, OP_MAKER_ID, OP_STATUS_READ,
         OP_CONFIG_READ, OP_OTP_READ, OP_WAKE: return K_OUT;
         OP_TWO_OUT, OP_FOUR_OUT, OP_TWO_ADDR_DATA,
         OP_FOUR_ADDR_DATA: return K_SILENT;
         OP_PAGE_PROG, OP_FOUR_PAGE_PROG, OP_STATUS_WRITE,
         OP_OTP_PROG: return K_IN;
         OP_SET_WRITE_EN, OP_CLR_WRITE_EN, OP_SMALL_ERASE, OP_DOUBLE_ERASE,
         OP_LARGE_ERASE, OP_ARRAY_ERASE_A, OP_ARRAY_ERASE_B, OP_CLEAR_FAIL,
         OP_SLEEP: return K_NODATA;
         default: return K_BAD;
      endcase
   endfunction : kind_of

   function automatic logic [1:0] addr_len(input logic [7:0] op);
      case (op)
         OP_READ, OP_FAST_READ, OP_TWO_OUT, OP_FOUR_OUT, OP_TWO_ADDR_DATA,
         OP_FOUR_ADDR_DATA, OP_MAKER_ID, OP_SMALL_ERASE, OP_DOUBLE_ERASE,
         OP_LARGE_ERASE, OP_PAGE_PROG, OP_FOUR_PAGE_PROG, OP_OTP_PROG,
         OP_OTP_READ: return ADDR_BYTES;
         default: return NO_BYTES;
      endcase
   endfunction : addr_len

   // Mode cycles are consumed as header bytes like dummies
   function automatic logic [1:0] dummy_len(input logic [7:0] op);
      case (op)
         OP_FAST_READ, OP_TWO_OUT, OP_FOUR_OUT, OP_OTP_READ,
         OP_TWO_ADDR_DATA: return ONE_BYTE;
         OP_FOUR_ADDR_DATA, OP_WAKE: return THREE_BYTES;
         default: return NO_BYTES;
      endcase
   endfunction : dummy_len

   function automatic logic [2:0] space_of(input logic [7:0] op);
      case (op)
         OP_OTP_READ: return SPACE_OTP;
         OP_IDENT: return SPACE_IDENT;
         OP_MAKER_ID: return SPACE_MAKER;
         OP_WAKE: return SPACE_SIGNATURE;
         OP_STATUS_READ: return SPACE_STATUS;
         OP_CONFIG_READ: return SPACE_CONFIG;
         default: return SPACE_ARRAY;
      endcase
   endfunction : space_of

   function automatic logic array_access(input logic [7:0] op);
      return (addr_len(op) != NO_BYTES) && (op != OP_MAKER_ID);
   endfunction : array_access

   function automatic sfd_state_type data_state(input logic [7:0] op);
      case (kind_of(op))
         K_OUT: return S_OUT;
         K_IN: return S_IN;
         K_NODATA: return S_END;
         default: return S_IGNORE;
      endcase
   endfunction : data_state

   ////////////////////////////////////////////////////////////////////
   // Pin sampling and edges
   logic sck_s;
   logic cs_n_s;
   logic si_s;
   logic sck_d;
   logic cs_n_d;

   sfd_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i({sck_i, cs_n_i, si_i}),
      .sync_o({sck_s, cs_n_s, si_s})
   );

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sck_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         cs_n_d <= cs_n_s;
      end
   end

   logic rise;
   logic fall;
   logic cs_rise;
   assign rise = sck_s & ~sck_d & ~cs_n_s;
   assign fall = ~sck_s & sck_d & ~cs_n_s;
   assign cs_rise = cs_n_s & ~cs_n_d;

   ////////////////////////////////////////////////////////////////////
   // Input shifter
   logic [2:0] bit_cnt;
   logic [6:0] sh_in;
   logic byte_done;
   logic [7:0] in_byte;
   assign byte_done = rise && (bit_cnt == 3'h7);
   assign in_byte = {sh_in, si_s};

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bit_cnt <= 3'h0;
         sh_in <= 7'h00;
      end else if (cs_n_s) begin
         bit_cnt <= 3'h0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         sh_in <= in_byte[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequence control
   sfd_state_type st;
   sfd_state_type next_st;
   logic [7:0] opcode;
   logic [1:0] ph_cnt;
   logic [23:0] addr;
   logic [23:0] fetch_addr;
   logic start_fetch;
   logic load_fall;
   logic fetch_go;
   logic [2:0] out_cnt;

   always_comb begin
      next_st = st;
      if (cs_n_s) begin
         next_st = S_OPCODE;
      end else if (byte_done) begin
         case (st)
            S_OPCODE: begin
               if ((deep_sleep_o && in_byte != OP_WAKE)
                   || (busy_i && array_access(in_byte))) begin
                  next_st = S_IGNORE;
               end else if (kind_of(in_byte) == K_BAD) begin
                  next_st = S_IGNORE;
               end else if (addr_len(in_byte) != NO_BYTES) begin
                  next_st = S_ADDR;
               end else if (dummy_len(in_byte) != NO_BYTES) begin
                  next_st = S_DUMMY;
               end else begin
                  next_st = data_state(in_byte);
               end
            end
            S_ADDR: begin
               if (ph_cnt == 2'h0) begin
                  next_st = (dummy_len(opcode) != NO_BYTES) ? S_DUMMY
                     : data_state(opcode);
               end
            end
            S_DUMMY: begin
               if (ph_cnt == 2'h0) begin
                  next_st = data_state(opcode);
               end
            end
            default: next_st = st;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= S_OPCODE;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         opcode <= 8'h00;
         ph_cnt <= 2'h0;
      end else if (byte_done && st == S_OPCODE) begin
         opcode <= in_byte;
         ph_cnt <= (addr_len(in_byte) != NO_BYTES) ? addr_len(in_byte) - 2'h1
            : dummy_len(in_byte) - 2'h1;
      end else if (byte_done && st == S_ADDR && ph_cnt == 2'h0) begin
         ph_cnt <= dummy_len(opcode) - 2'h1;
      end else if (byte_done && (st == S_ADDR || st == S_DUMMY)) begin
         ph_cnt <= ph_cnt - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read address and fetch requests
   assign start_fetch = byte_done && next_st == S_OUT && st != S_OUT;
   assign load_fall = fall && st == S_OUT && out_cnt == 3'h0;
   assign fetch_go = start_fetch | load_fall;
   assign fetch_addr = (st == S_ADDR) ? {addr[15:0], in_byte} : addr;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr <= 24'h000000;
      end else if (cs_n_s) begin
         addr <= 24'h000000;
      end else if (fetch_go) begin
         addr <= (fetch_addr + 24'h000001) & ADDR_MASK;
      end else if (byte_done && st == S_ADDR) begin
         addr <= fetch_addr;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_req_o <= 1'b0;
         rd_addr_o <= 24'h000000;
         rd_space_o <= SPACE_ARRAY;
      end else begin
         rd_req_o <= fetch_go;
         if (fetch_go) begin
            rd_addr_o <= fetch_addr;
            rd_space_o <= space_of(opcode);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output shifter on serial falling edges
   logic [7:0] nb;
   logic [7:0] cur;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nb <= 8'h00;
      end else if (rd_valid_i) begin
         nb <= rd_data_i;
      end
   end

   // A starved read shows the previous byte; the clock ratio prevents it
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_cnt <= 3'h0;
         cur <= 8'h00;
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
      end else if (cs_n_s) begin
         out_cnt <= 3'h0;
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
      end else if (fall && st == S_OUT) begin
         out_cnt <= out_cnt + 3'h1;
         so_oe_o <= 1'b1;
         if (out_cnt == 3'h0) begin
            so_o <= nb[7];
            cur <= {nb[6:0], 1'b0};
         end else begin
            so_o <= cur[7];
            cur <= {cur[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write data, execution and deep sleep
   logic push_ready;
   logic push_valid;
   logic flush;
   logic exec_ok;
   logic [DATA_CNT_W-1:0] data_cnt;

   assign push_valid = byte_done && st == S_IN;
   assign exec_ok = bit_cnt == 3'h0
      && (st == S_END || (st == S_IN && data_cnt != '0));
   // Discarded data must not reach the write engine
   assign flush = cs_rise && st == S_IN && !exec_ok;

   sfd_fifo #(.W(8), .D(DEPTH)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .flush_i(flush),
      .push_valid_i(push_valid),
      .push_data_i(in_byte),
      .push_ready_o(push_ready),
      .pop_valid_o(wr_valid_o),
      .pop_data_o(wr_data_o),
      .pop_ready_i(wr_ready_i)
   );

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         data_cnt <= '0;
         overflow_o <= 1'b0;
      end else if (cs_n_s) begin
         data_cnt <= '0;
      end else if (push_valid) begin
         if (data_cnt != '1) begin
            data_cnt <= data_cnt + 1'b1;
         end
         if (!push_ready) begin
            overflow_o <= 1'b1;
         end
      end else if (byte_done && st == S_OPCODE) begin
         overflow_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         exec_valid_o <= 1'b0;
         exec_cmd_o <= 8'h00;
         exec_addr_o <= 24'h000000;
         exec_len_o <= '0;
      end else begin
         exec_valid_o <= cs_rise && exec_ok;
         if (cs_rise && exec_ok) begin
            exec_cmd_o <= opcode;
            exec_addr_o <= addr;
            exec_len_o <= data_cnt;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         deep_sleep_o <= 1'b0;
      end else if (cs_rise && exec_ok && opcode == OP_SLEEP) begin
         deep_sleep_o <= 1'b1;
      end else if (byte_done && st == S_OPCODE && in_byte == OP_WAKE) begin
         deep_sleep_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_abort_on_deselect: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      cs_rise |=> !so_oe_o && !so_o)
      else $error("output still driven after deselect");

   a_exec_on_boundary: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec_valid_o |-> $past(bit_cnt) == 3'h0 && $past(cs_rise))
      else $error("command executed off a byte boundary");

   a_exec_single_pulse: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec_valid_o |=> !exec_valid_o)
      else $error("execute pulse longer than one cycle");

   a_ignore_stays_quiet: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st == S_IGNORE) |-> !so_oe_o && !rd_req_o)
      else $error("ignored command drove output");

   a_busy_blocks_read: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (byte_done && st == S_OPCODE && busy_i && in_byte == OP_READ)
      |=> st == S_IGNORE)
      else $error("array read accepted while busy");

   a_read_takes_addr: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (byte_done && st == S_OPCODE && in_byte == OP_READ && !busy_i
       && !deep_sleep_o) |=> st == S_ADDR && ph_cnt == 2'h2)
      else $error("read opcode did not start three address bytes");

   a_fast_takes_dummy: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (byte_done && st == S_ADDR && ph_cnt == 2'h0 && opcode == OP_FAST_READ)
      |=> st == S_DUMMY && ph_cnt == 2'h0)
      else $error("fast read skipped its dummy byte");

   a_addr_wraps_zero: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (fetch_go && fetch_addr == ADDR_MASK && !cs_n_s) |=> addr == 24'h000000)
      else $error("read address did not wrap to zero");

   a_first_fetch_addr: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      start_fetch |=> rd_req_o && rd_addr_o == $past(fetch_addr))
      else $error("first fetch used the wrong address");

   a_msb_leads_byte: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      load_fall |=> so_o == $past(nb[7]) && so_oe_o)
      else $error("byte did not start with its top bit");

endmodule : sfd_decoder

// ===== verif/sfd_host.sv
// Host serial master model: mode 0, sck half period of 5 clk.
// Assumes the bench calls its tasks just after a clk_sys_i rise.
module sfd_host (
   // Clock
   input wire logic clk_sys_i,
   // Serial pins
   input wire logic so_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : wt
   task automatic sel();
      sck_o <= 1'b0;
      wt(4);
      cs_n_o <= 1'b0;
      wt(4);
   endtask : sel
   // Sample so at the rise, well after the device moved it
   task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
      for (int i = 0; i < n; i++) begin
         sck_o <= 1'b0;
         si_o <= b[7-i];
         wt(5);
         r[7-i] = so_i;
         sck_o <= 1'b1;
         wt(5);
      end
   endtask : shift
   // Reads end with sck high so no extra fetch edge is made
   task automatic desel(input logic lo);
      if (lo) begin
         sck_o <= 1'b0;
      end
      si_o <= ~si_o;
      wt(5);
      cs_n_o <= 1'b1;
      wt(10);
   endtask : desel
endmodule : sfd_host

// ===== verif/sfd_decoder_tb_top.sv
// Bench for the command decoder: host model, storage and write stub.
// Assumes a 100 MHz clk_sys_i and a 22-bit array address.
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
   $display("Error %s expected %0h seen %0h", n, e, s); end end
module sfd_decoder_tb_top import sfd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, rd_valid_i = 1'b0, busy_i = 1'b0;
   logic wr_ready_i = 1'b0, oe_seen = 1'b0;
   logic [7:0] rd_data_i = 8'h00;
   logic sck, cs_n, si, so, so_oe, rd_req, ex_v, ovf, wr_v, slp;
   logic [2:0] rd_space;
   logic [23:0] rd_addr, ex_addr, a;
   logic [7:0] ex_cmd, wr_d, r, d;
   logic [DATA_CNT_W-1:0] ex_len;
   logic [40:0] ev, exp_ex[$], exp_rd[$], exp_wr[$];
   logic [7:0] ops [7] = '{OP_SET_WRITE_EN, OP_CLR_WRITE_EN, OP_ARRAY_ERASE_A,
      OP_ARRAY_ERASE_B, OP_SMALL_ERASE, OP_DOUBLE_ERASE, OP_LARGE_ERASE};
   int mismatches = 0, comparisons = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   sfd_host HOST (.clk_sys_i(clk_sys_i), .so_i(so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
   sfd_decoder DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .rd_req_o(rd_req),
      .rd_addr_o(rd_addr), .rd_space_o(rd_space), .rd_valid_i(rd_valid_i),
      .rd_data_i(rd_data_i),
      .busy_i(busy_i), .exec_valid_o(ex_v), .exec_cmd_o(ex_cmd), .exec_addr_o(ex_addr),
      .exec_len_o(ex_len), .deep_sleep_o(slp), .overflow_o(ovf), .wr_valid_o(wr_v),
      .wr_data_o(wr_d), .wr_ready_i(wr_ready_i));
   ////////////////////////////////////////////////////////////////////
   // Storage answers next cycle; monitor takes the oldest note
   always @(posedge clk_sys_i) begin
      rd_valid_i <= rd_req;
      rd_data_i <= rd_addr[7:0] ^ 8'hA5;
      if (so_oe) begin
         oe_seen <= 1'b1;
      end
      if (rd_req) begin
         ev = exp_rd.size() ? exp_rd.pop_front() : 'x;
         `CHK("rd_addr", ev, {rd_space, rd_addr})
      end
      if (ex_v) begin
         ev = exp_ex.size() ? exp_ex.pop_front() : 'x;
         `CHK("exec", ev, {ex_cmd, ex_addr, ex_len})
      end
      if (wr_v && wr_ready_i) begin
         ev = exp_wr.size() ? exp_wr.pop_front() : 'x;
         `CHK("wr_data", ev, wr_d)
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   task automatic tend(input string s);
      HOST.wt(20);
      `CHK("exec_left", 0, exp_ex.size())
      `CHK("rd_left", 0, exp_rd.size())
      `CHK("wr_left", 0, exp_wr.size())
      $display("%s done", s);
   endtask : tend
   task automatic head(input logic [7:0] op, input logic [23:0] ad, input int n);
      HOST.sel();
      HOST.shift(op, 8, r);
      for (int i = 2; i >= 3 - n; i--) begin
         HOST.shift(ad[8*i+:8], 8, r);
      end
   endtask : head
   // One fetch note per byte plus the prefetch of the next one
   task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int n,
      input int nd, input int nb, input logic [2:0] sp);
      for (int i = 0; i <= nb; i++) exp_rd.push_back(41'({sp, (ad + 24'(i)) & 24'h3FFFFF}));
      head(op, ad, n);
      for (int i = 0; i < nd; i++) HOST.shift(8'h00, 8, r);
      for (int i = 0; i < nb; i++) begin
         HOST.shift(8'h00, 8, r);
         `CHK("so_byte", 8'(ad + 24'(i)) ^ 8'hA5, r)
      end
      `CHK("so_oe", 1'b1, so_oe)
      HOST.desel(1'b0);
      `CHK("so_off", 1'b0, so_oe)
   endtask : rd
   initial begin
      #200us;
      mismatches++;
      final_report();
   end
   initial begin
      void'($urandom(32'h3C47));
      repeat (16) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      HOST.wt(4);
      // Read over the top of the array, then one with a dummy byte
      a = 24'h3FFFFE;
      rd(OP_READ, a, 3, 0, 3, SPACE_ARRAY);
      a = 24'($urandom() & 32'h3FFFFF);
      rd(OP_FAST_READ, a, 3, 1, 2, SPACE_ARRAY);
      tend("read_wrap");
      // Operand-free and address-only write commands
      for (int k = 0; k < 7; k++) begin
         a = (k > 3) ? 24'($urandom() & 32'h3FFFFF) : 24'h000000;
         exp_ex.push_back({ops[k], a, 9'h000});
         head(ops[k], a, (k > 3) ? 3 : 0);
         HOST.desel(1'b1);
      end
      // A command ending one bit past a byte boundary is discarded
      head(OP_SET_WRITE_EN, a, 0);
      HOST.shift(8'h00, 1, r);
      HOST.desel(1'b1);
      tend("write_ops");
      // Page program overfilling the stalled FIFO
      a = 24'($urandom() & 32'h3FFFFF);
      exp_ex.push_back({OP_PAGE_PROG, a, 9'h009});
      head(OP_PAGE_PROG, a, 3);
      for (int i = 0; i < 9; i++) begin
         d = 8'($urandom());
         if (i < 8) exp_wr.push_back(41'(d));
         HOST.shift(d, 8, r);
      end
      HOST.desel(1'b1);
      HOST.wt(10);
      `CHK("overflow", 1'b1, ovf)
      wr_ready_i <= 1'b1;
      tend("page_program");
      // Read while busy and an unknown opcode stay silent
      busy_i <= 1'b1;
      oe_seen = 1'b0;
      head(OP_READ, a, 3);
      HOST.shift(8'h00, 8, r);
      HOST.desel(1'b0);
      busy_i <= 1'b0;
      `CHK("busy_oe", 1'b0, oe_seen)
      head(8'hFF, a, 1);
      HOST.shift(8'h00, 8, r);
      HOST.desel(1'b1);
      `CHK("unknown_oe", 1'b0, oe_seen)
      tend("refusals");
      // Deep sleep refuses reads; wake with dummies reads the signature
      exp_ex.push_back({OP_SLEEP, 24'h000000, 9'h000});
      head(OP_SLEEP, a, 0);
      HOST.desel(1'b1);
      `CHK("sleep", 1'b1, slp)
      oe_seen = 1'b0;
      head(OP_READ, a, 3);
      HOST.shift(8'h00, 8, r);
      HOST.desel(1'b0);
      `CHK("sleep_oe", 1'b0, oe_seen)
      rd(OP_WAKE, 24'h000000, 0, 3, 1, SPACE_SIGNATURE);
      `CHK("awake", 1'b0, slp)
      tend("sleep_wake");
      final_report();
   end
endmodule : sfd_decoder_tb_top
